// file: design/pmc_pkg.sv
package pmc_pkg;
    // register addresses as seen on the register port
    localparam logic [31:0] IPC_ADDR = 32'h10001F40;
    localparam logic [31:0] RSVD_A_ADDR = 32'h10001F42;
    localparam logic [31:0] RSVD_B_ADDR = 32'h10001F44;
    localparam logic [31:0] RSVD_C_ADDR = 32'h10001F46;
    localparam logic [31:0] MAP_BASE_ADDR = 32'h20080010;

    // local-bus windows onto the backplane
    localparam logic [31:0] IO_WIN_LO = 32'h10000000;
    localparam logic [31:0] IO_WIN_HI = 32'h10001FFF;
    localparam logic [31:0] MEM_WIN_LO = 32'h14000000;
    localparam logic [31:0] MEM_WIN_HI = 32'h143FFFFF;

    // interprocessor communication register fields
    localparam int IPC_MEMERR_BIT = 15;
    localparam int IPC_INVAL_BIT = 14;
    localparam int IPC_DBIE_BIT = 6;
    localparam int IPC_EAE_BIT = 5;
    localparam int IPC_DBRQ_BIT = 0;

    // map base register fields, bits outside read as zero
    localparam int MAP_BASE_LSB = 15;
    localparam int MAP_BASE_MSB = 28;
    localparam logic [3:0] LONG_BE = 4'hF;

    // page map register in memory
    localparam int PMR_VALID_BIT = 31;
    localparam int PAGE_LSB = 9;
    localparam logic [8:0] PAGE_LAST_BYTE = 9'h1FF;

    // cache geometry
    localparam int ENTRIES = 16;
    localparam int ENTRY_IDX_W = 4;

    // doorbell interrupt identity
    localparam logic [15:0] DB_VECTOR = 16'h0204;
    localparam logic [4:0] DB_LEVEL = 5'h14;
    localparam logic [4:0] BR_AFTER_LEVEL = 5'h17;

    // level-14 sources in falling priority
    localparam logic [1:0] SRC_CONSOLE = 2'h0;
    localparam logic [1:0] SRC_TIMER = 2'h1;
    localparam logic [1:0] SRC_DOORBELL = 2'h2;
    localparam logic [1:0] SRC_BR4 = 2'h3;

    // cache entry: valid in 33, tag in 32:20, page in 19:0
    typedef struct packed {
        logic entry_valid_flag;
        logic [12:0] cached_page_tag;
        logic [19:0] page;
    } pmc_entry_type;

    typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_FETCH} pmc_xlat_type;
    typedef enum logic [1:0] {IK_IDLE, IK_DIN, IK_IAK} pmc_iak_type;
endpackage

// file: design/pmc_top.sv
`timescale 1ns/1ps
module pmc_top (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_ADDR,
    input wire logic [3:0] REG_BE,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_LOCAL_MASTER,
    output logic [31:0] REG_RDATA,
    // dma address translation
    input wire logic DMA_REQ,
    input wire logic [21:0] DMA_ADDR,
    output logic DMA_READY,
    output logic DMA_GRANT,
    output logic DMA_NORESP,
    output logic [28:0] DMA_MEM_ADDR,
    input wire logic DMA_DONE,
    input wire logic [21:0] DMA_END_ADDR,
    // map register fetch from memory
    output logic MEM_RD_REQ,
    output logic [28:0] MEM_RD_ADDR,
    input wire logic MEM_RD_ACK,
    input wire logic [31:0] MEM_RD_DATA,
    // map register written by the cpu
    input wire logic MAPREG_WR,
    input wire logic [12:0] MAPREG_PAGE,
    // error and reset events
    input wire logic DMA_ERR_SET,
    input wire logic DMA_ERR_CLR,
    input wire logic LOCAL_TIMER_EXP,
    input wire logic IO_RESET_WR,
    input wire logic DC_POWER_GOOD,
    input wire logic CFG_DC_POWER_GOOD_HALT,
    // cpu local bus to backplane address
    input wire logic [31:0] LB_ADDR,
    output logic LB_IO_HIT,
    output logic LB_MEM_HIT,
    output logic [21:0] BUS_ADDR,
    output logic BUS_BBS7,
    // level-14 interrupt sources
    input wire logic CONSOLE_IRQ,
    input wire logic TIMER_IRQ,
    input wire logic DB_GRANT,
    output logic IRQ14,
    output logic [1:0] IRQ14_SRC,
    output logic [15:0] IRQ14_VECTOR,
    output logic [4:0] IRQ_LEVEL,
    // backplane interrupt requests and acknowledge
    input wire logic [3:0] BUS_BR,
    output logic [3:0] BR_PENDING,
    input wire logic IAK_START,
    output logic BUS_DIN,
    output logic BUS_IAK,
    input wire logic BUS_RPLY,
    input wire logic [15:0] BUS_DATA,
    output logic [15:0] IAK_VECTOR,
    output logic IAK_DONE
);
    import pmc_pkg::*;

    typedef struct packed {
        pmc_entry_type [ENTRIES-1:0] ent;
        logic [ENTRY_IDX_W-1:0] fifo_ptr;
        pmc_xlat_type st;
        logic [12:0] cur_tag;
        logic [8:0] cur_off;
        logic is_pf;
        logic pf_pend;
        logic [12:0] pf_tag;
        logic stale;
        logic mem_req;
        logic [28:0] mem_addr;
        logic grant;
        logic noresp;
        logic [28:0] dma_addr;
        logic memerr;
        logic db_ie;
        logic eae;
        logic db_rq;
        logic [MAP_BASE_MSB:MAP_BASE_LSB] map_base;
        logic [31:0] rdata;
        logic io_hit;
        logic mem_hit;
        logic [21:0] bus_addr;
        logic bbs7;
        logic irq14;
        logic [1:0] irq_src;
        logic [15:0] irq_vec;
        logic [4:0] irq_lvl;
        logic [2:0] dc_power_good_s;
        logic [3:0] br_s1;
        logic [3:0] br_s2;
        logic rply_s1;
        logic rply_s2;
        logic [15:0] data_s1;
        logic [15:0] data_s2;
        pmc_iak_type ik;
        logic din;
        logic iak;
        logic [15:0] iak_vec;
        logic iak_done;
    } pmc_state_type;

    pmc_state_type q, d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic hit;
    logic [ENTRY_IDX_W-1:0] hit_idx;
    logic pwr_clr;
    logic ipc_lo_wr, ipc_hi_wr, base_wr, inval_all;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // associative compare against every tag at once
    always_comb begin
        hit = 1'b0;
        hit_idx = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (q.ent[i].entry_valid_flag && q.ent[i].cached_page_tag == q.cur_tag) begin
                hit = 1'b1;
                hit_idx = ENTRY_IDX_W'(i);
            end
        end
    end

    // decode of register accesses and clearing events
    assign pwr_clr = q.dc_power_good_s[2] & ~q.dc_power_good_s[1] & ~CFG_DC_POWER_GOOD_HALT;
    assign ipc_lo_wr = REG_WR && REG_ADDR == IPC_ADDR && REG_BE[0];
    assign ipc_hi_wr = REG_WR && REG_ADDR == IPC_ADDR && REG_BE[1];
    assign base_wr = REG_WR && REG_ADDR == MAP_BASE_ADDR && REG_BE == LONG_BE;
    assign inval_all = pwr_clr | IO_RESET_WR | base_wr | (ipc_hi_wr & REG_WDATA[IPC_INVAL_BIT]);

    always_comb begin
        d = q;
        d.grant = 1'b0;
        d.noresp = 1'b0;
        d.iak_done = 1'b0;
        // pin synchronisers, first stage feeds only the second
        d.dc_power_good_s = {q.dc_power_good_s[1:0], DC_POWER_GOOD};
        d.br_s1 = BUS_BR;
        d.br_s2 = q.br_s1;
        d.rply_s1 = BUS_RPLY;
        d.rply_s2 = q.rply_s1;
        d.data_s1 = BUS_DATA;
        d.data_s2 = q.data_s1;
        // flush and single-entry invalidate
        for (int i = 0; i < ENTRIES; i++) begin
            if (inval_all || (MAPREG_WR && q.ent[i].cached_page_tag == MAPREG_PAGE)) begin
                d.ent[i].entry_valid_flag = 1'b0;
            end
        end
        if (q.st == ST_FETCH && (inval_all || (MAPREG_WR && MAPREG_PAGE == q.cur_tag))) begin
            d.stale = 1'b1; // a fetch in flight must not refill a flushed cache
        end
        // page-end transfer queues a prefetch of the following page
        if (DMA_DONE && DMA_END_ADDR[8:0] == PAGE_LAST_BYTE) begin
            d.pf_pend = 1'b1;
            d.pf_tag = DMA_END_ADDR[21:PAGE_LSB] + 13'h0001;
        end
        // translation sequencer; prefetch wins over a new transfer
        unique case (q.st)
            ST_IDLE: begin
                d.stale = 1'b0;
                if (q.pf_pend) begin
                    d.pf_pend = DMA_DONE && DMA_END_ADDR[8:0] == PAGE_LAST_BYTE;
                    d.cur_tag = q.pf_tag;
                    d.is_pf = 1'b1;
                    d.st = ST_LOOK;
                end else if (DMA_REQ) begin
                    d.cur_tag = DMA_ADDR[21:PAGE_LSB];
                    d.cur_off = DMA_ADDR[8:0];
                    d.is_pf = 1'b0;
                    d.st = ST_LOOK;
                end
            end
            ST_LOOK: begin
                if (!q.eae) begin
                    d.noresp = ~q.is_pf;
                    d.st = ST_IDLE;
                end else if (hit) begin
                    d.grant = ~q.is_pf;
                    d.dma_addr = {q.ent[hit_idx].page, q.cur_off};
                    d.st = ST_IDLE;
                end else begin
                    d.mem_req = 1'b1;
                    d.mem_addr = {q.map_base, 15'h0000} + {14'h0000, q.cur_tag, 2'h0};
                    d.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (MEM_RD_ACK) begin
                    d.mem_req = 1'b0;
                    d.st = ST_IDLE;
                    if (MEM_RD_DATA[PMR_VALID_BIT]) begin
                        if (!q.stale && !d.stale) begin
                            d.ent[q.fifo_ptr] = {1'b1, q.cur_tag, MEM_RD_DATA[19:0]};
                            d.fifo_ptr = q.fifo_ptr + 4'h1;
                        end
                        d.grant = ~q.is_pf;
                        d.dma_addr = {MEM_RD_DATA[19:0], q.cur_off};
                    end else begin
                        d.noresp = ~q.is_pf;
                    end
                end
            end
            default: d.st = ST_IDLE;
        endcase
        // memory error bit: set wins over any clear
        if ((ipc_hi_wr && REG_WDATA[IPC_MEMERR_BIT]) || pwr_clr || IO_RESET_WR || DMA_ERR_CLR) begin
            d.memerr = 1'b0;
        end
        if (DMA_ERR_SET || LOCAL_TIMER_EXP) begin
            d.memerr = 1'b1;
        end
        // enables are writable only while the local side is master
        if (ipc_lo_wr && REG_LOCAL_MASTER) begin
            d.db_ie = REG_WDATA[IPC_DBIE_BIT];
            d.eae = REG_WDATA[IPC_EAE_BIT];
        end
        if (pwr_clr || IO_RESET_WR) begin
            d.db_ie = 1'b0;
        end
        if (pwr_clr) begin
            d.eae = 1'b0;
        end
        // doorbell request: grant clears, a new write-one wins
        if (DB_GRANT) begin
            d.db_rq = 1'b0;
        end
        if (ipc_lo_wr && REG_WDATA[IPC_DBRQ_BIT] && q.db_ie) begin
            d.db_rq = 1'b1;
        end
        if (!d.db_ie || pwr_clr) begin
            d.db_rq = 1'b0;
        end
        // map base survives bus initialize; only a longword write loads it
        if (base_wr) begin
            d.map_base = REG_WDATA[MAP_BASE_MSB:MAP_BASE_LSB];
        end
        // register read data, reserved words and unused bits as zero
        d.rdata = 32'h00000000;
        if (REG_RD && REG_ADDR == IPC_ADDR) begin
            d.rdata[IPC_MEMERR_BIT] = q.memerr;
            d.rdata[IPC_DBIE_BIT] = q.db_ie;
            d.rdata[IPC_EAE_BIT] = q.eae;
            d.rdata[IPC_DBRQ_BIT] = q.db_rq;
        end else if (REG_RD && REG_ADDR == MAP_BASE_ADDR) begin
            d.rdata[MAP_BASE_MSB:MAP_BASE_LSB] = q.map_base;
        end
        // local-bus windows onto backplane io and memory space
        d.io_hit = LB_ADDR >= IO_WIN_LO && LB_ADDR <= IO_WIN_HI;
        d.mem_hit = LB_ADDR >= MEM_WIN_LO && LB_ADDR <= MEM_WIN_HI;
        d.bbs7 = d.io_hit;
        if (d.io_hit) begin
            d.bus_addr = {9'h000, LB_ADDR[12:0]};
        end else if (d.mem_hit) begin
            d.bus_addr = LB_ADDR[21:0];
        end else begin
            d.bus_addr = 22'h000000;
        end
        // level-14 ranking: console, timers, doorbell, then BR4
        d.irq14 = 1'b1;
        d.irq_vec = 16'h0000;
        d.irq_lvl = DB_LEVEL;
        if (CONSOLE_IRQ) begin
            d.irq_src = SRC_CONSOLE;
        end else if (TIMER_IRQ) begin
            d.irq_src = SRC_TIMER;
        end else if (q.db_rq) begin
            d.irq_src = SRC_DOORBELL;
            d.irq_vec = DB_VECTOR;
        end else if (q.br_s2[0]) begin
            d.irq_src = SRC_BR4;
            d.irq_lvl = BR_AFTER_LEVEL;
        end else begin
            d.irq14 = 1'b0;
            d.irq_src = SRC_CONSOLE;
        end
        // bus interrupt acknowledge: DIN first, IAK one cycle later, both held until reply
        unique case (q.ik)
            IK_IDLE: begin
                if (IAK_START && q.br_s2 != 4'h0) begin
                    d.din = 1'b1;
                    d.ik = IK_DIN;
                end
            end
            IK_DIN: begin
                d.iak = 1'b1;
                d.ik = IK_IAK;
            end
            IK_IAK: begin
                if (q.rply_s2) begin
                    d.iak_vec = q.data_s2;
                    d.iak_done = 1'b1;
                    d.din = 1'b0;
                    d.iak = 1'b0;
                    d.ik = IK_IDLE;
                end
            end
            default: d.ik = IK_IDLE;
        endcase
    end
    // one register for all state; sync reset copy clears it asynchronously
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0; // flags and map base start clear
        end else begin
            q <= d;
        end
    end
    // outputs straight from state
    assign REG_RDATA = q.rdata;
    assign DMA_READY = q.st == ST_IDLE && !q.pf_pend;
    assign DMA_GRANT = q.grant;
    assign DMA_NORESP = q.noresp;
    assign DMA_MEM_ADDR = q.dma_addr;
    assign MEM_RD_REQ = q.mem_req;
    assign MEM_RD_ADDR = q.mem_addr;
    assign LB_IO_HIT = q.io_hit;
    assign LB_MEM_HIT = q.mem_hit;
    assign BUS_ADDR = q.bus_addr;
    assign BUS_BBS7 = q.bbs7;
    assign IRQ14 = q.irq14;
    assign IRQ14_SRC = q.irq_src;
    assign IRQ14_VECTOR = q.irq_vec;
    assign IRQ_LEVEL = q.irq_lvl;
    assign BR_PENDING = q.br_s2;
    assign BUS_DIN = q.din;
    assign BUS_IAK = q.iak;
    assign IAK_VECTOR = q.iak_vec;
    assign IAK_DONE = q.iak_done;
endmodule

// file: tb/pmc_asserts.sv
`timescale 1ns/1ps
module pmc_asserts
import pmc_pkg::*;
(
    // clock, reset and register port
    input wire logic CLK, RST_N, REG_RD,
    input wire logic [31:0] REG_ADDR, REG_RDATA, LB_ADDR,
    // translation
    input wire logic DMA_REQ, DMA_READY, DMA_GRANT, DMA_NORESP, MEM_RD_REQ,
    input wire logic [21:0] DMA_ADDR, BUS_ADDR,
    input wire logic [28:0] DMA_MEM_ADDR, MEM_RD_ADDR,
    // windows and interrupts
    input wire logic LB_IO_HIT, LB_MEM_HIT, BUS_BBS7, IRQ14, BUS_DIN, BUS_IAK, IAK_DONE,
    input wire logic [1:0] IRQ14_SRC,
    input wire logic [15:0] IRQ14_VECTOR,
    input wire logic [4:0] IRQ_LEVEL
);
    logic [8:0] off_q;
    logic [31:0] lb_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // offset of the accepted request and last local address
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            off_q <= 9'h0;
            lb_q <= 32'h0;
        end else begin
            if (DMA_REQ && DMA_READY) off_q <= DMA_ADDR[8:0];
            lb_q <= LB_ADDR;
        end
    end
    chk_read_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
        else $error("read data not zero outside a read");
    chk_ipc_zeros: assert property ($past(REG_RD) && $past(REG_ADDR) == IPC_ADDR |->
        REG_RDATA[31:16] == 16'h0 && REG_RDATA[14:7] == 8'h0 && REG_RDATA[4:1] == 4'h0)
        else $error("comm register unused bits not zero");
    chk_base_zeros: assert property ($past(REG_RD) && $past(REG_ADDR) == MAP_BASE_ADDR |->
        REG_RDATA[31:29] == 3'h0 && REG_RDATA[14:0] == 15'h0)
        else $error("map base unused bits not zero");
    chk_page_offset: assert property (DMA_GRANT |-> DMA_MEM_ADDR[8:0] == off_q)
        else $error("page offset not passed through");
    chk_answer_bound: assert property (DMA_REQ && DMA_READY |-> ##[2:60] (DMA_GRANT || DMA_NORESP))
        else $error("dma request left unanswered");
    chk_fetch_align: assert property ($rose(MEM_RD_REQ) |-> MEM_RD_ADDR[1:0] == 2'h0)
        else $error("map fetch address not word aligned");
    chk_io_window: assert property (lb_q inside {[IO_WIN_LO:IO_WIN_HI]} |->
        LB_IO_HIT && BUS_BBS7 && BUS_ADDR == {9'h0, lb_q[12:0]})
        else $error("io window translation wrong");
    chk_mem_window: assert property (lb_q inside {[MEM_WIN_LO:MEM_WIN_HI]} |->
        LB_MEM_HIT && !BUS_BBS7 && BUS_ADDR == lb_q[21:0])
        else $error("memory window translation wrong");
    chk_db_ident: assert property (IRQ14 && IRQ14_SRC == SRC_DOORBELL |->
        IRQ14_VECTOR == DB_VECTOR && IRQ_LEVEL == DB_LEVEL)
        else $error("doorbell vector or level wrong");
    chk_iak_order: assert property ($rose(BUS_DIN) |=> BUS_IAK && BUS_DIN)
        else $error("acknowledge not following input strobe");
    chk_iak_hold: assert property (BUS_IAK |-> BUS_DIN)
        else $error("acknowledge without input strobe");
    cover property (DMA_GRANT);
    cover property (DMA_NORESP);
    cover property (IAK_DONE);
endmodule
bind pmc_top pmc_asserts u_chk (.*);

// file: tb/pmc_far_model.sv
`timescale 1ns/1ps
module pmc_far_model (
    // map fetch from memory
    input wire logic CLK, RST_N, MEM_RD_REQ,
    input wire logic [28:0] MEM_RD_ADDR,
    input wire logic [3:0] lat,
    output logic MEM_RD_ACK,
    output logic [31:0] MEM_RD_DATA,
    // interrupting backplane device
    input wire logic BUS_IAK,
    input wire logic [15:0] vec,
    output logic BUS_RPLY,
    output logic [15:0] BUS_DATA
);
    logic [3:0] cnt_q;
    logic [31:0] last_q, word;
    // base is 32K aligned, so offset bits give the page; top page bit marks it invalid
    assign word = {~MEM_RD_ADDR[14], 11'h0, 7'h55, MEM_RD_ADDR[14:2]};
    // released lines show the inverse of the last value
    assign MEM_RD_DATA = MEM_RD_ACK ? word : ~last_q;
    assign BUS_DATA = BUS_RPLY ? vec : ~vec;
    // one ack pulse after lat idle cycles; reply follows the acknowledge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            MEM_RD_ACK <= 1'b0;
            cnt_q <= 4'h0;
            last_q <= 32'h0;
            BUS_RPLY <= 1'b0;
        end else begin
            BUS_RPLY <= BUS_IAK;
            MEM_RD_ACK <= 1'b0;
            if (MEM_RD_ACK) begin
                last_q <= word;
                cnt_q <= 4'h0;
            end else if (MEM_RD_REQ && cnt_q == lat) MEM_RD_ACK <= 1'b1;
            else if (MEM_RD_REQ) cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// file: tb/pmc_top_tb.sv
`timescale 1ns/1ps
module pmc_top_tb;
    import pmc_pkg::*;
    logic CLK, RST_N, REG_WR, REG_RD, REG_LOCAL_MASTER, DMA_REQ, DMA_READY, DMA_GRANT, DMA_NORESP;
    logic DMA_DONE, MEM_RD_REQ, MEM_RD_ACK, MAPREG_WR, DMA_ERR_SET, DMA_ERR_CLR, LOCAL_TIMER_EXP;
    logic IO_RESET_WR, DC_POWER_GOOD, CFG_DC_POWER_GOOD_HALT, LB_IO_HIT, LB_MEM_HIT, BUS_BBS7, CONSOLE_IRQ;
    logic TIMER_IRQ, DB_GRANT, IRQ14, IAK_START, BUS_DIN, BUS_IAK, BUS_RPLY, IAK_DONE, rd_q, eae, ans;
    logic [31:0] REG_ADDR, REG_WDATA, REG_RDATA, MEM_RD_DATA, LB_ADDR, a;
    logic [28:0] DMA_MEM_ADDR, MEM_RD_ADDR;
    logic [21:0] DMA_ADDR, DMA_END_ADDR, BUS_ADDR;
    logic [15:0] IRQ14_VECTOR, BUS_DATA, IAK_VECTOR, vec, v;
    logic [13:0] base_exp;
    logic [12:0] MAPREG_PAGE;
    logic [7:0] ev;
    logic [4:0] IRQ_LEVEL;
    logic [3:0] REG_BE, BUS_BR, BR_PENDING, lat;
    logic [1:0] IRQ14_SRC;
    logic [31:0] q_reg[$];
    logic [28:0] q_dma[$];
    logic [15:0] q_iak[$];
    int errors, n_tests, seed, fetches, i, n;
    pmc_top dut (.*);
    pmc_far_model far (.*);
    assign {IAK_START, DB_GRANT, IO_RESET_WR, LOCAL_TIMER_EXP, DMA_ERR_CLR, DMA_ERR_SET, MAPREG_WR, DMA_DONE} = ev;
    assign ans = DMA_GRANT | DMA_NORESP;
    always #4 CLK = ~CLK;
    task cmp(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task end_sim;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // bounded wait for a level, judged at the falling edge
    task automatic wt(ref logic s);
        int k;
        @(negedge CLK);
        for (k = 0; k < 100 && s !== 1'b1; k++) @(negedge CLK);
        if (s !== 1'b1) begin
            errors++;
            $display("CHECK FAILED wait expected 1 seen %b", s);
            end_sim;
        end
    endtask
    task pulse(logic [7:0] m);
        @(posedge CLK) ev <= m;
        @(posedge CLK) ev <= 8'h0;
    endtask
    task wr(logic [31:0] ad, logic [3:0] be, logic [31:0] d);
        @(posedge CLK) {REG_ADDR, REG_BE, REG_WDATA, REG_WR} <= {ad, be, d, 1'b1};
        @(posedge CLK) REG_WR <= 1'b0;
    endtask
    task rd(logic [31:0] ad, logic [31:0] e);
        q_reg.push_back(e);
        @(posedge CLK) {REG_ADDR, REG_RD} <= {ad, 1'b1};
        @(posedge CLK) REG_RD <= 1'b0;
    endtask
    // one transfer at a random offset; f is the number of map fetches it should cause
    task dma(logic [12:0] p, int f);
        int f0;
        logic [21:0] ad;
        ad = {p, 9'($random(seed))};
        q_dma.push_back((p[12] || !eae) ? 29'h1FFFFFFF : {7'h55, ad});
        wt(DMA_READY);
        f0 = fetches;
        @(posedge CLK) {DMA_ADDR, DMA_REQ, lat} <= {ad, 1'b1, 4'($random(seed))};
        @(posedge CLK) DMA_REQ <= 1'b0;
        wt(ans);
        @(posedge CLK);
        cmp("fetches", f, fetches - f0);
    endtask
    task irq(logic [23:0] e);
        repeat (4) @(negedge CLK);
        cmp("irq", e, {IRQ14, IRQ14_SRC, IRQ14_VECTOR, IRQ_LEVEL});
    endtask
    // scoreboard: oldest note against each result as it appears
    always @(posedge CLK) begin
        if (MEM_RD_ACK) begin
            fetches++;
            cmp("map base", base_exp, MEM_RD_ADDR[28:15]);
        end
        if (rd_q) cmp("reg read", q_reg.pop_front(), REG_RDATA);
        if (DMA_GRANT) cmp("dma addr", q_dma.pop_front(), DMA_MEM_ADDR);
        if (DMA_NORESP) cmp("dma noresp", q_dma.pop_front(), 29'h1FFFFFFF);
        if (IAK_DONE) cmp("iak vector", q_iak.pop_front(), IAK_VECTOR);
        rd_q <= REG_RD;
    end
    initial begin
        CLK = 0;
        RST_N = 0;
        seed = 32'hF184;
        {REG_WR, REG_RD, REG_LOCAL_MASTER, DMA_REQ, CONSOLE_IRQ, TIMER_IRQ, CFG_DC_POWER_GOOD_HALT, rd_q} = '0;
        {REG_ADDR, REG_WDATA, LB_ADDR, DMA_ADDR, DMA_END_ADDR, vec, MAPREG_PAGE, ev, REG_BE, BUS_BR} = '0;
        {lat, base_exp, fetches, errors, n_tests} = '0;
        DC_POWER_GOOD = 1;
        eae = 1;
        repeat (8) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        // reset values and refused writes while not master
        rd(IPC_ADDR, 32'h0);
        rd(RSVD_A_ADDR, 32'h0);
        wr(IPC_ADDR, 4'h1, 32'h61);
        rd(IPC_ADDR, 32'h0);
        REG_LOCAL_MASTER <= 1'b1;
        wr(IPC_ADDR, 4'h1, 32'h60);
        rd(IPC_ADDR, 32'h60);
        wr(MAP_BASE_ADDR, 4'h3, 32'hFFFFFFFF);
        rd(MAP_BASE_ADDR, 32'h0);
        base_exp = 14'($random(seed));
        wr(MAP_BASE_ADDR, 4'hF, {3'h7, base_exp, 15'h7FFF});
        rd(MAP_BASE_ADDR, {3'h0, base_exp, 15'h0});
        // fill all entries, then hits and first-in first-out eviction
        for (i = 0; i < 16; i++) dma(i[12:0], 1);
        dma(13'h0, 0);
        dma(13'h10, 1);
        dma(13'h1, 0);
        dma(13'h0, 1);
        dma(13'h1, 1);
        dma(13'h1000, 1);
        dma(13'h1000, 1);
        // page-end transfer fetches the next map word ahead
        n = fetches;
        DMA_END_ADDR <= {13'h20, 9'h1FF};
        pulse(8'h01);
        wt(DMA_READY);
        cmp("prefetch", n + 1, fetches);
        dma(13'h21, 0);
        // flush sources and single-entry invalidate
        wr(IPC_ADDR, 4'h2, 32'h4000);
        dma(13'h21, 1);
        pulse(8'h20);
        dma(13'h21, 1);
        dma(13'h22, 1);
        MAPREG_PAGE <= 13'h21;
        pulse(8'h02);
        dma(13'h22, 0);
        dma(13'h21, 1);
        wr(MAP_BASE_ADDR, 4'hF, {3'h0, base_exp, 15'h0});
        dma(13'h22, 1);
        rd(IPC_ADDR, 32'h20);
        // external access disabled
        wr(IPC_ADDR, 4'h1, 32'h0);
        eae = 0;
        dma(13'h22, 0);
        // doorbell and level-14 priority
        wr(IPC_ADDR, 4'h1, 32'h40);
        wr(IPC_ADDR, 4'h1, 32'h41);
        rd(IPC_ADDR, 32'h41);
        irq({1'b1, SRC_DOORBELL, DB_VECTOR, DB_LEVEL});
        @(posedge CLK) {CONSOLE_IRQ, BUS_BR} <= 5'h11;
        irq({1'b1, SRC_CONSOLE, 16'h0, DB_LEVEL});
        @(posedge CLK) {CONSOLE_IRQ, TIMER_IRQ} <= 2'h1;
        irq({1'b1, SRC_TIMER, 16'h0, DB_LEVEL});
        @(posedge CLK) TIMER_IRQ <= 1'b0;
        irq({1'b1, SRC_DOORBELL, DB_VECTOR, DB_LEVEL});
        pulse(8'h40);
        irq({1'b1, SRC_BR4, 16'h0, BR_AFTER_LEVEL});
        cmp("br pending", 32'h1, BR_PENDING);
        rd(IPC_ADDR, 32'h40);
        // acknowledge of a backplane request
        v = 16'($random(seed));
        q_iak.push_back(v);
        @(posedge CLK) vec <= v;
        pulse(8'h80);
        wt(IAK_DONE);
        @(posedge CLK) BUS_BR <= 4'h0;
        // memory error bit, byte writes
        pulse(8'h04);
        rd(IPC_ADDR, 32'h8040);
        wr(IPC_ADDR, 4'h2, 32'h80FF);
        rd(IPC_ADDR, 32'h40);
        pulse(8'h10);
        rd(IPC_ADDR, 32'h8040);
        pulse(8'h08);
        rd(IPC_ADDR, 32'h40);
        pulse(8'h04);
        pulse(8'h20);
        rd(IPC_ADDR, 32'h0);
        // power-ok loss clears only while the halt option is off
        wr(IPC_ADDR, 4'h1, 32'h60);
        eae = 1;
        dma(13'h22, 1);
        pulse(8'h04);
        for (i = 0; i < 2; i++) begin
            @(posedge CLK) {CFG_DC_POWER_GOOD_HALT, DC_POWER_GOOD} <= {~i[0], 1'b0};
            repeat (4) @(posedge CLK);
            DC_POWER_GOOD <= 1'b1;
            rd(IPC_ADDR, i[0] ? 32'h0 : 32'h8060);
        end
        wr(IPC_ADDR, 4'h1, 32'h20);
        dma(13'h22, 1);
        // local-bus windows
        for (i = 0; i < 8; i++) begin
            a = $random(seed);
            a = i[0] ? {19'h08000, a[12:0]} : {10'h050, a[21:0]};
            @(posedge CLK) LB_ADDR <= a;
            @(posedge CLK);
            @(negedge CLK);
            cmp("bus addr", i[0] ? {9'h0, a[12:0]} : a[21:0], BUS_ADDR);
            cmp("bbs7", i[0], BUS_BBS7);
        end
        end_sim;
    end
endmodule
